// file: misc_ctrl_pkg.sv
// Purpose: Shared constants for the converter misc control register bank
// Assumes: Classic Wishbone, 32-bit data, register index times four is the byte address
// Notes:   Registers are eight bits wide in the low byte lane
package misc_ctrl_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register indices; byte address is index * 4
  localparam logic [6:0] REF_SRC_IDX   = 7'h38;
  localparam logic [6:0] STAMP_IDX     = 7'h3b;
  localparam logic [6:0] EMPH_IDX      = 7'h48;
  localparam logic [6:0] ROUTE_IDX     = 7'h60;
  localparam logic [6:0] CAL_EN_IDX    = 7'h61;
  localparam logic [6:0] STATUS_IDX    = 7'h70;

  // Reset values
  localparam logic [7:0] REF_SRC_RST   = 8'h00;
  localparam logic [7:0] STAMP_RST     = 8'h00;
  localparam logic [7:0] EMPH_RST      = 8'h00;
  localparam logic [7:0] ROUTE_RST     = 8'h01;
  localparam logic [7:0] CAL_EN_RST    = 8'h01;

  // Field positions
  localparam int unsigned REF_SRC_BIT  = 0;
  localparam int unsigned STAMP_ON_BIT = 0;
  localparam int unsigned PECL_BIT     = 1;
  localparam int unsigned EMPH_LSB     = 0;
  localparam int unsigned EMPH_MSB     = 2;
  localparam int unsigned EXTRA_BIT    = 3;
  localparam int unsigned SWAP_BIT     = 4;
  localparam int unsigned SEL_LSB      = 0;
  localparam int unsigned SEL_MSB      = 1;
  localparam int unsigned CAL_EN_BIT   = 0;
  localparam int unsigned ST_SRC_A_BIT = 0;
  localparam int unsigned ST_SRC_B_BIT = 1;
  localparam int unsigned ST_FAULT_BIT = 2;
  localparam int unsigned ST_CAL_BIT   = 3;

  // Single-channel input select codes
  localparam logic [1:0] SEL_RESERVED  = 2'h0;
  localparam logic [1:0] SEL_INPUT_A   = 2'h1;
  localparam logic [1:0] SEL_INPUT_B   = 2'h2;
  localparam logic [1:0] SEL_DUAL      = 2'h3;

  // Analog source of a channel
  typedef enum logic {
    SRC_A = 1'b0,
    SRC_B = 1'b1
  } source_type;
endpackage

// file: input_router.sv
// Purpose: Applies the analog input routing when a calibration starts
// Assumes: apply_in pulses one cycle at each calibration start
// Notes:   Routing changes only at a calibration start, never mid-run
`timescale 1ns/1ps
module input_router
  import misc_ctrl_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               srst_in,
  input  wire logic               apply_in,
  input  wire logic               single_mode_in,
  input  wire logic               dual_swap_in,
  input  wire logic [1:0]         single_select_in,
  output misc_ctrl_pkg::source_type chan_a_source_out,
  output misc_ctrl_pkg::source_type chan_b_source_out
);
  import misc_ctrl_pkg::*;

  source_type a_next;
  source_type b_next;

  always_comb begin
    if (single_mode_in) begin                      // RULE7
      case (single_select_in)                      // RULE8
        SEL_INPUT_B: begin
          a_next = SRC_B;
          b_next = SRC_B;
        end
        SEL_DUAL: begin
          a_next = SRC_A;
          b_next = SRC_B;
        end
        default: begin
          // Reserved code falls back to input A
          a_next = SRC_A;
          b_next = SRC_A;
        end
      endcase
    end else begin                                 // RULE9
      a_next = dual_swap_in ? SRC_B : SRC_A;       // RULE6
      b_next = dual_swap_in ? SRC_A : SRC_B;       // RULE6
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      chan_a_source_out <= SRC_A;
      chan_b_source_out <= SRC_A;
    end else if (apply_in) begin                   // RULE10
      chan_a_source_out <= a_next;
      chan_b_source_out <= b_next;
    end
  end
endmodule

// file: cal_sequencer.sv
// Purpose: Calibration run/hold, divider reset and link ordering watch
// Assumes: link_output_on_in is the serial link enable level
// Notes:   Order faults are only flagged; the host owns the sequence
`timescale 1ns/1ps
module cal_sequencer
  import misc_ctrl_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic srst_in,
  input  wire logic cal_enable_in,
  input  wire logic link_output_on_in,
  input  wire logic fault_clear_in,
  output logic      cal_run_out,
  output logic      divider_reset_out,
  output logic      cal_start_out,
  output logic      order_fault_out
);
  import misc_ctrl_pkg::*;

  logic link_prev_reg;
  logic fault_next;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cal_run_out       <= 1'b0;
      divider_reset_out <= 1'b1;
    end else begin
      cal_run_out       <= cal_enable_in;           // RULE11
      divider_reset_out <= ~cal_enable_in;          // RULE12
    end
  end

  // First cycle after reset starts a run, since enable resets high
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cal_start_out <= 1'b0;
    end else begin
      cal_start_out <= cal_enable_in & ~cal_run_out; // RULE11
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_output_on_in;
    end
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    fault_next = order_fault_out & ~fault_clear_in;
    if (link_output_on_in & ~link_prev_reg & ~cal_enable_in) begin
      fault_next = 1'b1;                            // RULE14
    end
    if (link_output_on_in & cal_run_out & ~cal_enable_in) begin
      fault_next = 1'b1;                            // RULE15
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      order_fault_out <= 1'b0;
    end else begin
      order_fault_out <= fault_next;
    end
  end
endmodule

// file: misc_ctrl_regs.sv
// Purpose: Misc control register bank of the converter on a Wishbone slave port
// Assumes: Classic single-cycle Wishbone; link mode and link enable come from outside
// Notes:   Each register is one aligned word; unmapped reads return zero
// Function
// RULE1: Reference bit 0 set selects the analog core supply as voltage reference.
// RULE2: Stamp control bit 1 puts the time stamp receiver in low-voltage PECL mode.
// RULE3: Stamp control bit 0 turns the time stamp receiver on, off after reset.
// RULE4: Emphasis bits 2:0 give one level shared by all 16 lanes of both groups.
// RULE5: Emphasis bit 3 adds a little more and a longer pre-emphasis on top.
// RULE6: In dual modes routing bit 4 keeps inputs straight at 0 and crosses at 1.
// RULE7: The swap bit does nothing while the link format is single channel.
// RULE8: In single mode select 1 is input A, 2 input B, 3 dual interleave, 0 reserved.
// RULE9: The single select field does nothing outside single channel modes.
// RULE10: New routing takes effect only when a calibration has run.
// RULE11: Calibration enable bit 0 resets high; high runs, low holds the engine.
// RULE12: Clearing calibration enable also resets the digital and link dividers.
// RULE13: Host clears calibration enable before changing guarded settings, then sets it.
// RULE14: Host sets calibration enable before turning the link output on.
// RULE15: Host turns the link output off before clearing calibration enable.
// RULE16: Reserved bits store and read back what is written and do nothing else.
`timescale 1ns/1ps
module misc_ctrl_regs
  import misc_ctrl_pkg::*;
(
  input  wire logic                               clock_in,
  input  wire logic                               srst_in,
  input  wire logic                               wb_cyc_in,
  input  wire logic                               wb_stb_in,
  input  wire logic                               wb_we_in,
  input  wire logic [misc_ctrl_pkg::ADDR_W-1:0]   wb_adr_in,
  input  wire logic [3:0]                         wb_sel_in,
  input  wire logic [misc_ctrl_pkg::DATA_W-1:0]   wb_dat_in,
  output logic      [misc_ctrl_pkg::DATA_W-1:0]   wb_dat_out,
  output logic                                    wb_ack_out,
  input  wire logic                               link_single_mode_in,
  input  wire logic                               link_output_on_in,
  output logic                                    reference_source_select_out,
  output logic                                    stamp_receiver_on_out,
  output logic                                    stamp_input_pecl_select_out,
  output logic      [2:0]                         lane_preemphasis_level_out,
  output logic                                    lane_preemphasis_extra_out,
  output misc_ctrl_pkg::source_type               chan_a_source_out,
  output misc_ctrl_pkg::source_type               chan_b_source_out,
  output logic                                    cal_run_out,
  output logic                                    divider_reset_out
);
  import misc_ctrl_pkg::*;

  logic [REG_W-1:0] ref_src_reg;
  logic [REG_W-1:0] stamp_reg;
  logic [REG_W-1:0] emph_reg;
  logic [REG_W-1:0] route_reg;
  logic [REG_W-1:0] cal_en_reg;
  logic             cal_start;
  logic             order_fault;
  logic             req;
  logic             wr;
  logic [6:0]       idx;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] rdata;
  logic             fault_clear;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  assign req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr    = req & wb_we_in & wb_sel_in[0];
  assign idx   = wb_adr_in[ADDR_W-1:2];
  assign wbyte = wb_dat_in[REG_W-1:0];
  assign fault_clear = wr & hit(idx, STATUS_IDX) & wbyte[ST_FAULT_BIT];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  // Full bytes stored so reserved bits read back as written
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ref_src_reg <= REF_SRC_RST;
    end else if (wr && hit(idx, REF_SRC_IDX)) begin
      ref_src_reg <= wbyte;                         // RULE16
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stamp_reg <= STAMP_RST;                       // RULE3
    end else if (wr && hit(idx, STAMP_IDX)) begin
      stamp_reg <= wbyte;                           // RULE16
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      emph_reg <= EMPH_RST;
    end else if (wr && hit(idx, EMPH_IDX)) begin
      emph_reg <= wbyte;                            // RULE16
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      route_reg <= ROUTE_RST;                       // RULE8
    end else if (wr && hit(idx, ROUTE_IDX)) begin
      route_reg <= wbyte;                           // RULE16
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cal_en_reg <= CAL_EN_RST;                     // RULE11
    end else if (wr && hit(idx, CAL_EN_IDX)) begin
      cal_en_reg <= wbyte;                          // RULE16
    end
  end

  always_comb begin
    rdata = '0;
    case (idx)
      REF_SRC_IDX: rdata = ref_src_reg;
      STAMP_IDX:   rdata = stamp_reg;
      EMPH_IDX:    rdata = emph_reg;
      ROUTE_IDX:   rdata = route_reg;
      CAL_EN_IDX:  rdata = cal_en_reg;
      STATUS_IDX: begin
        rdata[ST_SRC_A_BIT] = chan_a_source_out;
        rdata[ST_SRC_B_BIT] = chan_b_source_out;
        rdata[ST_FAULT_BIT] = order_fault;
        rdata[ST_CAL_BIT]   = cal_run_out;
      end
      default:     rdata = '0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wb_dat_out <= '0;
    end else if (req) begin
      wb_dat_out <= {{(DATA_W-REG_W){1'b0}}, rdata};
    end
  end

  // Analog-side controls, one flop stage from the registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      reference_source_select_out <= 1'b0;
      stamp_receiver_on_out       <= 1'b0;
      stamp_input_pecl_select_out <= 1'b0;
    end else begin
      reference_source_select_out <= ref_src_reg[REF_SRC_BIT]; // RULE1
      stamp_receiver_on_out       <= stamp_reg[STAMP_ON_BIT];  // RULE3
      stamp_input_pecl_select_out <= stamp_reg[PECL_BIT];      // RULE2
    end
  end

  // One shared setting fans out to all sixteen lanes
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lane_preemphasis_level_out <= 3'h0;
      lane_preemphasis_extra_out <= 1'b0;
    end else begin
      lane_preemphasis_level_out <= emph_reg[EMPH_MSB:EMPH_LSB]; // RULE4
      lane_preemphasis_extra_out <= emph_reg[EXTRA_BIT];         // RULE5
    end
  end

  cal_sequencer u_cal (
    .clock_in          (clock_in),
    .srst_in           (srst_in),
    .cal_enable_in     (cal_en_reg[CAL_EN_BIT]),
    .link_output_on_in (link_output_on_in),
    .fault_clear_in    (fault_clear),
    .cal_run_out       (cal_run_out),
    .divider_reset_out (divider_reset_out),
    .cal_start_out     (cal_start),
    .order_fault_out   (order_fault)
  );

  // Host must re-run calibration after editing routing
  input_router u_route (
    .clock_in          (clock_in),
    .srst_in           (srst_in),
    .apply_in          (cal_start),
    .single_mode_in    (link_single_mode_in),
    .dual_swap_in      (route_reg[SWAP_BIT]),
    .single_select_in  (route_reg[SEL_MSB:SEL_LSB]),
    .chan_a_source_out (chan_a_source_out),
    .chan_b_source_out (chan_b_source_out)
  );

  ref_source_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE1
    reference_source_select_out == $past(ref_src_reg[REF_SRC_BIT]))
    else $error("reference select does not follow its bit");

  stamp_pecl_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE2
    stamp_input_pecl_select_out == $past(stamp_reg[PECL_BIT]))
    else $error("pecl select does not follow its bit");

  stamp_on_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE3
    wr && hit(idx, STAMP_IDX) |-> ##2 stamp_receiver_on_out == $past(wbyte[STAMP_ON_BIT], 2))
    else $error("stamp receiver enable not applied two cycles after write");

  emph_level_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE4
    wr && hit(idx, EMPH_IDX) |-> ##2 lane_preemphasis_level_out == $past(wbyte[2:0], 2))
    else $error("lane emphasis level not applied");

  emph_extra_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE5
    $changed(emph_reg[EXTRA_BIT]) |=> lane_preemphasis_extra_out == emph_reg[EXTRA_BIT])
    else $error("emphasis extra not applied");

  dual_swap_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE6
    cal_start && !link_single_mode_in && route_reg[SWAP_BIT]
    |=> chan_a_source_out == SRC_B && chan_b_source_out == SRC_A)
    else $error("swap not applied in dual mode");

  single_sel_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE8
    cal_start && link_single_mode_in && route_reg[SEL_MSB:SEL_LSB] == SEL_INPUT_B
    |=> chan_a_source_out == SRC_B && chan_b_source_out == SRC_B)
    else $error("single select input b not applied");

  route_hold_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE10
    !cal_start |=> $stable(chan_a_source_out) && $stable(chan_b_source_out))
    else $error("routing changed without a calibration start");

  cal_hold_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE11
    wr && hit(idx, CAL_EN_IDX) && !wbyte[CAL_EN_BIT] |-> ##2 !cal_run_out)
    else $error("calibration not held after clearing enable");

  div_reset_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE12
    divider_reset_out == !cal_run_out)
    else $error("divider reset not tied to calibration hold");

  reserved_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    wr && hit(idx, CAL_EN_IDX) |=> cal_en_reg == $past(wbyte))
    else $error("reserved bits not stored as written");

  bus_ack_a: assert property (@(posedge clock_in) disable iff (srst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held for more than one cycle");

  bus_answer_a: assert property (@(posedge clock_in) disable iff (srst_in)
    req |=> wb_ack_out)
    else $error("request not acknowledged");

  single_a_sel_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE8
    cal_start && link_single_mode_in && route_reg[SEL_MSB:SEL_LSB] == SEL_INPUT_A
    |=> chan_a_source_out == SRC_A && chan_b_source_out == SRC_A)
    else $error("single select input a not applied");

  single_dual_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE8
    cal_start && link_single_mode_in && route_reg[SEL_MSB:SEL_LSB] == SEL_DUAL
    |=> chan_a_source_out == SRC_A && chan_b_source_out == SRC_B)
    else $error("single select dual interleave not applied");

  single_rsvd_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE8
    cal_start && link_single_mode_in && route_reg[SEL_MSB:SEL_LSB] == SEL_RESERVED
    |=> chan_a_source_out == SRC_A && chan_b_source_out == SRC_A)
    else $error("reserved select not on input a");

  dual_straight_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE6
    cal_start && !link_single_mode_in && !route_reg[SWAP_BIT]
    |=> chan_a_source_out == SRC_A && chan_b_source_out == SRC_B)
    else $error("straight routing not applied in dual mode");

  swap_ignored_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE7
    cal_start && link_single_mode_in && route_reg[SEL_MSB:SEL_LSB] != SEL_DUAL
    |=> chan_a_source_out == chan_b_source_out)
    else $error("swap bit acted in single mode");

  select_ignored_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE9
    cal_start && !link_single_mode_in |=> chan_a_source_out != chan_b_source_out)
    else $error("single select acted in dual mode");

  reset_ctrl_a: assert property (@(posedge clock_in) // RULE3
    srst_in |=> !stamp_receiver_on_out && !reference_source_select_out)
    else $error("controls not off after reset");

  cal_reset_a: assert property (@(posedge clock_in) // RULE11
    srst_in |=> cal_en_reg[CAL_EN_BIT] && divider_reset_out)
    else $error("calibration enable reset value wrong");

  cal_run_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE11
    wr && hit(idx, CAL_EN_IDX) && wbyte[CAL_EN_BIT] |-> ##2 cal_run_out)
    else $error("calibration not run after setting enable");

  div_clear_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE12
    wr && hit(idx, CAL_EN_IDX) && !wbyte[CAL_EN_BIT] |-> ##2 divider_reset_out)
    else $error("dividers not reset after clearing enable");

  order_on_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE14
    $rose(link_output_on_in) && !cal_en_reg[CAL_EN_BIT] |=> order_fault)
    else $error("link on before calibration not flagged");

  order_off_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE15
    link_output_on_in && cal_run_out && !cal_en_reg[CAL_EN_BIT] |=> order_fault)
    else $error("calibration off under live link not flagged");

  fault_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
    order_fault && !fault_clear |=> order_fault)
    else $error("order fault dropped without a clear");

  read_data_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    req && !wb_we_in && hit(idx, REF_SRC_IDX) |=> wb_dat_out[REG_W-1:0] == $past(ref_src_reg))
    else $error("reference register read wrong");

  sel_ignore_a: assert property (@(posedge clock_in) disable iff (srst_in)
    req && wb_we_in && !wb_sel_in[0] |=> $stable(ref_src_reg) && $stable(stamp_reg))
    else $error("write without low lane stored");

  reserved_ref_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    wr && hit(idx, REF_SRC_IDX) |=> ref_src_reg == $past(wbyte))
    else $error("reference byte not stored as written");

  reserved_stamp_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    wr && hit(idx, STAMP_IDX) |=> stamp_reg == $past(wbyte))
    else $error("stamp byte not stored as written");

  reserved_emph_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    wr && hit(idx, EMPH_IDX) |=> emph_reg == $past(wbyte))
    else $error("emphasis byte not stored as written");

  reserved_route_a: assert property (@(posedge clock_in) disable iff (srst_in) // RULE16
    wr && hit(idx, ROUTE_IDX) |=> route_reg == $past(wbyte))
    else $error("routing byte not stored as written");
endmodule

// file: adc_misc_control_regs_test.sv
// Purpose: Self-checking bench for the converter misc control register bank
// Assumes: Classic Wishbone single cycles, ack one cycle after the request is taken
// Notes:   Routing is judged after a full calibration off/on restart, except one check that a bare routing write leaves it unchanged
`timescale 1ns/1ps
module adc_misc_control_regs_test;
  import misc_ctrl_pkg::*;

  logic        clock_in;
  logic        srst_in;
  logic        wb_cyc_in;
  logic        wb_stb_in;
  logic        wb_we_in;
  logic [8:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        link_single_mode_in;
  logic        link_output_on_in;
  logic        ref_sel;
  logic        stamp_on;
  logic        stamp_pecl;
  logic [2:0]  emph_level;
  logic        emph_extra;
  source_type  src_a;
  source_type  src_b;
  logic        cal_run;
  logic        div_reset;
  int          n_fail;
  int          tests_run;
  int          cycles;

  misc_ctrl_regs dut_u (
    .clock_in                    (clock_in),
    .srst_in                     (srst_in),
    .wb_cyc_in                   (wb_cyc_in),
    .wb_stb_in                   (wb_stb_in),
    .wb_we_in                    (wb_we_in),
    .wb_adr_in                   (wb_adr_in),
    .wb_sel_in                   (wb_sel_in),
    .wb_dat_in                   (wb_dat_in),
    .wb_dat_out                  (wb_dat_out),
    .wb_ack_out                  (wb_ack_out),
    .link_single_mode_in         (link_single_mode_in),
    .link_output_on_in           (link_output_on_in),
    .reference_source_select_out (ref_sel),
    .stamp_receiver_on_out       (stamp_on),
    .stamp_input_pecl_select_out (stamp_pecl),
    .lane_preemphasis_level_out  (emph_level),
    .lane_preemphasis_extra_out  (emph_extra),
    .chan_a_source_out           (src_a),
    .chan_b_source_out           (src_b),
    .cal_run_out                 (cal_run),
    .divider_reset_out           (div_reset)
  );

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [6:0] idx, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_sel_in <= sel;
    wb_dat_in <= wd;
    do @(posedge clock_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] val);
    logic [31:0] rd;
    wb_xfer(1'b1, idx, 4'h1, {24'h0, val}, rd);
  endtask

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, idx, 4'h1, 32'h0, rd);
    check_word(rd, {24'h0, exp});
  endtask

  // Controls land one flop after the register; let those edges pass
  task automatic settle();
    repeat (2) @(posedge clock_in);
  endtask

  // Link goes off before calibration stops and on only after it runs again
  task automatic cal_restart();
    @(posedge clock_in);
    link_output_on_in <= 1'b0;
    wr(CAL_EN_IDX, 8'h00);
    settle();
    check_bit(cal_run, 1'b0);
    check_bit(div_reset, 1'b1);
    wr(CAL_EN_IDX, 8'h01);
    settle();
    check_bit(cal_run, 1'b1);
    check_bit(div_reset, 1'b0);
    @(posedge clock_in);
    link_output_on_in <= 1'b1;
  endtask

  task automatic test_reset_values();
    rd_chk(REF_SRC_IDX, 8'h00);
    rd_chk(STAMP_IDX, 8'h00);
    rd_chk(EMPH_IDX, 8'h00);
    rd_chk(ROUTE_IDX, 8'h01);
    rd_chk(CAL_EN_IDX, 8'h01);
    check_bit(stamp_on, 1'b0);
    check_bit(cal_run, 1'b1);
    check_bit(src_a, SRC_A);
    check_bit(src_b, SRC_A);
    $display("test reset_values done");
  endtask

  task automatic test_simple_controls();
    wr(REF_SRC_IDX, 8'h01);
    settle();
    check_bit(ref_sel, 1'b1);
    wr(REF_SRC_IDX, 8'hfe);
    settle();
    check_bit(ref_sel, 1'b0);
    rd_chk(REF_SRC_IDX, 8'hfe);
    wr(STAMP_IDX, 8'h03);
    settle();
    check_bit(stamp_on, 1'b1);
    check_bit(stamp_pecl, 1'b1);
    wr(STAMP_IDX, 8'hfd);
    settle();
    check_bit(stamp_on, 1'b1);
    check_bit(stamp_pecl, 1'b0);
    rd_chk(STAMP_IDX, 8'hfd);
    $display("test simple_controls done");
  endtask

  task automatic test_emphasis();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 8'ha0 | 8'(i);
      wr(EMPH_IDX, v);
      settle();
      check_bit(emph_extra, v[3]);
      check_word({29'h0, emph_level}, {29'h0, v[2:0]});
      rd_chk(EMPH_IDX, v);
    end
    $display("test emphasis done");
  endtask

  task automatic route_step(input logic single, input logic [7:0] v,
                            input source_type ea, input source_type eb);
    @(posedge clock_in);
    link_single_mode_in <= single;
    wr(ROUTE_IDX, v);
    rd_chk(ROUTE_IDX, v);
    cal_restart();
    check_bit(src_a, ea);
    check_bit(src_b, eb);
  endtask

  task automatic test_routing();
    wr(ROUTE_IDX, 8'h12);
    settle();
    check_bit(src_a, SRC_A);
    check_bit(src_b, SRC_A);
    route_step(1'b1, 8'h12, SRC_B, SRC_B);
    route_step(1'b1, 8'h13, SRC_A, SRC_B);
    route_step(1'b1, 8'hfd, SRC_A, SRC_A);
    route_step(1'b0, 8'h12, SRC_B, SRC_A);
    route_step(1'b0, 8'h01, SRC_A, SRC_B);
    $display("test routing done");
  endtask

  // Link is on and routing is straight dual when this starts
  task automatic test_order_faults();
    wr(CAL_EN_IDX, 8'h00);
    rd_chk(STATUS_IDX, 8'h06);
    wr(STATUS_IDX, 8'h04);
    rd_chk(STATUS_IDX, 8'h02);
    @(posedge clock_in);
    link_output_on_in <= 1'b0;
    @(posedge clock_in);
    link_output_on_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rd_chk(STATUS_IDX, 8'h06);
    link_output_on_in <= 1'b0;
    wr(CAL_EN_IDX, 8'h01);
    wr(STATUS_IDX, 8'h04);
    settle();
    rd_chk(STATUS_IDX, 8'h0a);
    $display("test order_faults done");
  endtask

  task automatic test_refused_writes();
    logic [31:0] rd;
    wb_xfer(1'b1, REF_SRC_IDX, 4'h0, 32'hff, rd);
    rd_chk(REF_SRC_IDX, 8'hfe);
    wb_xfer(1'b1, 7'h10, 4'hf, 32'hff, rd);
    rd_chk(7'h10, 8'h00);
    $display("test refused_writes done");
  endtask

  initial begin
    srst_in             = 1'b1;
    wb_cyc_in           = 1'b0;
    wb_stb_in           = 1'b0;
    wb_we_in            = 1'b0;
    wb_adr_in           = 9'h000;
    wb_sel_in           = 4'h0;
    wb_dat_in           = 32'h0;
    link_single_mode_in = 1'b1;
    link_output_on_in   = 1'b0;
    n_fail              = 0;
    tests_run           = 0;
    cycles              = 0;
    repeat (16) @(posedge clock_in);
    srst_in <= 1'b0;
    settle();
    test_reset_values();
    test_simple_controls();
    test_emphasis();
    test_routing();
    test_order_faults();
    test_refused_writes();
    report_and_stop();
  end
endmodule
